// ### shared/ptc_pkg.sv
/*
 Shared constants and packet descriptor types for the packet timestamp
 conformance checker.
 Assumes a parser upstream delivers one decoded packet descriptor per cycle.
*/
// Function
// - Picosecond fraction becomes sample count: ((ps+1) times freq) divided by 1,000,000,000.
// - Absolute index is integer seconds times frequency plus fractional sample count.
// - Sample/context stream continuous when index plus count equals next index.
// - Flow control step is next absolute index minus current absolute index.
// - Release at reference point equals timestamp plus reported timestamp adjustment; the checker computes no release point.
// - Measure offset of every timestamp against capture time reference; record variability.
// - Compute offset slope; referenced source needs zero slope, others may drift.
// - Time-continuous sink needs continuous input and emits no packets.
// - Sink master issues flow control with timing and buffer level.
// - Reported buffer level equals how early samples arrive at correct rate; the checker only flags a follower level that changes.
// - Following source: constant buffer level, sample slope matches flow slope.
// - Sample-count format timestamps are all valid sample indexes.
package ptc_pkg;
  localparam int IDX_W = 64;
  localparam logic [63:0] PS_DIVISOR = 64'h0000_0000_3b9a_ca00;
  localparam logic [63:0] PS_ROUND = 64'h0000_0000_0000_0001;
  localparam logic [1:0] PKT_SAMPLE = 2'h0;
  localparam logic [1:0] PKT_CONTEXT = 2'h1;
  localparam logic [1:0] PKT_FLOW = 2'h2;
  localparam logic [2:0] ERR_CONT_BIT = 3'h0;
  localparam logic [2:0] ERR_STEP_BIT = 3'h1;
  localparam logic [2:0] ERR_SLOPE_BIT = 3'h2;
  localparam logic [2:0] ERR_EMIT_BIT = 3'h3;
  localparam logic [2:0] ERR_LEVEL_BIT = 3'h4;
  localparam logic [2:0] ERR_FSLOPE_BIT = 3'h5;
  localparam int ERR_W = 6;

  typedef enum logic [3:0] {
    CAT_NON_TIME_RELEASE_SRC = 4'h0,
    CAT_NON_TIME_RELEASE_SINK = 4'h1,
    CAT_TIME_CONTINUOUS_SRC = 4'h2,
    CAT_TIME_CONTINUOUS_SINK = 4'h3,
    CAT_FOLLOWER = 4'h4,
    CAT_MASTER = 4'h5,
    CAT_SRC_BURST = 4'h6,
    CAT_SINK_BURST = 4'h7
  } ptc_cat_t;

  typedef struct packed {
    logic [1:0] kind;
    logic fractional_timestamp_format;
    logic [31:0] int_sec;
    logic [63:0] frac;
    logic [31:0] sample_cnt;
    logic [63:0] capture_time;
    logic [31:0] buf_level;
  } ptc_pkt_t;

  typedef struct packed {
    logic [63:0] abs_idx;
    logic [63:0] step;
    logic [63:0] offset;
    logic [63:0] slope;
    logic [63:0] jitter;
    logic [ERR_W-1:0] err;
  } ptc_meas_t;
endpackage

// ### src/ptc_checker.sv
/*
 Packet timestamp conformance checker: converts timestamps to absolute
 sample indexes and checks continuity, step, offset slope and buffer level.
 Assumes descriptors from same-clock logic, one per valid cycle, and a
 capture time reference already expressed in sample periods.
*/
`timescale 1ns/100ps
module ptc_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pkt_valid,
  input wire ptc_pkg::ptc_pkt_t pkt,
  input wire logic [63:0] sample_freq,
  input wire ptc_pkg::ptc_cat_t category,
  input wire logic time_of_day_reference,
  output logic pkt_ready,
  output ptc_pkg::ptc_meas_t meas,
  output logic meas_valid,
  output logic err_any
);
  typedef enum logic [1:0] {
    ST_FIRST = 2'b01,
    ST_RUN = 2'b10
  } ptc_st_t;

  ptc_st_t st_q, st_d;
  logic [63:0] frac_samples;
  logic [63:0] abs_idx;
  logic [63:0] next_exp_q, next_exp_d;
  logic [63:0] fc_idx_q, fc_idx_d;
  logic fc_seen_q, fc_seen_d;
  logic [63:0] step_q, step_d;
  logic step_seen_q, step_seen_d;
  logic [63:0] off_q, off_d;
  logic [63:0] slope_q, slope_d;
  logic [63:0] fslope_q, fslope_d;
  logic [63:0] foff_q, foff_d;
  logic [63:0] jit_q, jit_d;
  logic [31:0] lvl_q, lvl_d;
  logic lvl_seen_q, lvl_seen_d;
  logic [ptc_pkg::ERR_W-1:0] err_q, err_d;
  logic meas_valid_q, meas_valid_d;
  logic [63:0] cur_off;
  logic [63:0] cur_slope;
  logic is_flow;
  logic emits;

  // Single-cycle divide is costly but keeps latency fixed at one cycle
  assign frac_samples = pkt.fractional_timestamp_format
    ? ((pkt.frac + ptc_pkg::PS_ROUND) * sample_freq) / ptc_pkg::PS_DIVISOR
    : pkt.frac;
  assign abs_idx = {32'h0, pkt.int_sec} * sample_freq + frac_samples;
  assign cur_off = pkt.capture_time - abs_idx;
  assign is_flow = (pkt.kind == ptc_pkg::PKT_FLOW);
  assign cur_slope = is_flow ? (cur_off - foff_q) : (cur_off - off_q);
  assign emits = (category != ptc_pkg::CAT_TIME_CONTINUOUS_SINK)
    && (category != ptc_pkg::CAT_NON_TIME_RELEASE_SINK)
    && (category != ptc_pkg::CAT_SINK_BURST);
  assign pkt_ready = 1'b1;

  always_comb
  begin
    st_d = st_q;
    next_exp_d = next_exp_q;
    fc_idx_d = fc_idx_q;
    fc_seen_d = fc_seen_q;
    step_d = step_q;
    step_seen_d = step_seen_q;
    off_d = off_q;
    slope_d = slope_q;
    fslope_d = fslope_q;
    foff_d = foff_q;
    jit_d = jit_q;
    lvl_d = lvl_q;
    lvl_seen_d = lvl_seen_q;
    err_d = err_q;
    meas_valid_d = 1'b0;
    if (pkt_valid)
    begin
      meas_valid_d = 1'b1;
      if (!emits)
      begin
        err_d[ptc_pkg::ERR_EMIT_BIT] = 1'b1;
      end
      if (is_flow)
      begin
        if (fc_seen_q)
        begin
          step_d = abs_idx - fc_idx_q;
          step_seen_d = 1'b1;
          fslope_d = cur_slope;
          if (step_seen_q && (abs_idx - fc_idx_q) != step_q)
          begin
            err_d[ptc_pkg::ERR_STEP_BIT] = 1'b1;
          end
        end
        fc_idx_d = abs_idx;
        fc_seen_d = 1'b1;
        foff_d = cur_off;
        // Follower level must hold steady once timestamps lead enough
        if (category == ptc_pkg::CAT_FOLLOWER && lvl_seen_q && pkt.buf_level != lvl_q)
        begin
          err_d[ptc_pkg::ERR_LEVEL_BIT] = 1'b1;
        end
        lvl_d = pkt.buf_level;
        lvl_seen_d = 1'b1;
      end
      else
      begin
        if (st_q == ST_RUN)
        begin
          if (abs_idx != next_exp_q)
          begin
            err_d[ptc_pkg::ERR_CONT_BIT] = 1'b1;
          end
          slope_d = cur_slope;
          jit_d = (cur_slope > jit_q) ? cur_slope : jit_q;
          if (time_of_day_reference && cur_slope != 64'h0)
          begin
            err_d[ptc_pkg::ERR_SLOPE_BIT] = 1'b1;
          end
          if (category == ptc_pkg::CAT_FOLLOWER && step_seen_q && cur_slope != fslope_q)
          begin
            err_d[ptc_pkg::ERR_FSLOPE_BIT] = 1'b1;
          end
        end
        next_exp_d = abs_idx + {32'h0, pkt.sample_cnt};
        off_d = cur_off;
        st_d = ST_RUN;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_q <= ST_FIRST;
      next_exp_q <= 64'h0;
      fc_idx_q <= 64'h0;
      fc_seen_q <= 1'b0;
      step_q <= 64'h0;
      step_seen_q <= 1'b0;
      off_q <= 64'h0;
      slope_q <= 64'h0;
      fslope_q <= 64'h0;
      foff_q <= 64'h0;
      jit_q <= 64'h0;
      lvl_q <= 32'h0;
      lvl_seen_q <= 1'b0;
      err_q <= '0;
      meas_valid_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      next_exp_q <= next_exp_d;
      fc_idx_q <= fc_idx_d;
      fc_seen_q <= fc_seen_d;
      step_q <= step_d;
      step_seen_q <= step_seen_d;
      off_q <= off_d;
      slope_q <= slope_d;
      fslope_q <= fslope_d;
      foff_q <= foff_d;
      jit_q <= jit_d;
      lvl_q <= lvl_d;
      lvl_seen_q <= lvl_seen_d;
      err_q <= err_d;
      meas_valid_q <= meas_valid_d;
    end
  end

  logic [63:0] last_idx_q;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      last_idx_q <= 64'h0;
    end
    else if (pkt_valid)
    begin
      last_idx_q <= abs_idx;
    end
  end

  assign meas.abs_idx = last_idx_q;
  assign meas.step = step_q;
  assign meas.offset = off_q;
  assign meas.slope = slope_q;
  assign meas.jitter = jit_q;
  assign meas.err = err_q;
  assign meas_valid = meas_valid_q;
  assign err_any = |err_q;

  property p_sticky;
    @(posedge sys_clk) disable iff (rst) err_any |=> err_any;
  endproperty
  a_sticky: assert property (p_sticky) else $error("error flag dropped");

  property p_cont;
    @(posedge sys_clk) disable iff (rst)
      (pkt_valid && !is_flow && st_q == ST_RUN && abs_idx != next_exp_q)
      |=> meas.err[0];
  endproperty
  a_cont: assert property (p_cont) else $error("continuity gap missed");

  property p_next;
    @(posedge sys_clk) disable iff (rst)
      (pkt_valid && !is_flow) |=> next_exp_q == $past(abs_idx) + {32'h0, $past(pkt.sample_cnt)};
  endproperty
  a_next: assert property (p_next) else $error("expected index wrong");

  property p_idx;
    @(posedge sys_clk) disable iff (rst)
      (pkt_valid && !pkt.fractional_timestamp_format)
      |=> meas.abs_idx == {32'h0, $past(pkt.int_sec)} * $past(sample_freq) + $past(pkt.frac);
  endproperty
  a_idx: assert property (p_idx) else $error("absolute index wrong");

  property p_ps;
    @(posedge sys_clk) disable iff (rst)
      (pkt_valid && pkt.fractional_timestamp_format && pkt.int_sec == 32'h0)
      |=> meas.abs_idx == (($past(pkt.frac) + 64'h1) * $past(sample_freq))
        / 64'h0000_0000_3b9a_ca00;
  endproperty
  a_ps: assert property (p_ps) else $error("picosecond conversion wrong");

  property p_step;
    @(posedge sys_clk) disable iff (rst)
      (pkt_valid && is_flow && fc_seen_q) |=> step_q == $past(abs_idx) - $past(fc_idx_q);
  endproperty
  a_step: assert property (p_step) else $error("step wrong");

  property p_slope;
    @(posedge sys_clk) disable iff (rst)
      (pkt_valid && !is_flow && st_q == ST_RUN && time_of_day_reference && cur_slope != 64'h0)
      |=> meas.err[2];
  endproperty
  a_slope: assert property (p_slope) else $error("slope fault missed");

  property p_offset;
    @(posedge sys_clk) disable iff (rst)
      (pkt_valid && !is_flow) |=> meas.offset == $past(pkt.capture_time) - $past(abs_idx);
  endproperty
  a_offset: assert property (p_offset) else $error("offset wrong");

  property p_emit;
    @(posedge sys_clk) disable iff (rst)
      (pkt_valid && category == ptc_pkg::CAT_TIME_CONTINUOUS_SINK) |=> meas.err[3];
  endproperty
  a_emit: assert property (p_emit) else $error("sink emission missed");

  c_cont_err: cover property (@(posedge sys_clk) disable iff (rst) $rose(meas.err[0]));
  c_step_err: cover property (@(posedge sys_clk) disable iff (rst) $rose(meas.err[1]));
  c_flow_run: cover property (@(posedge sys_clk) disable iff (rst)
    pkt_valid && is_flow ##1 pkt_valid && is_flow);
  c_clean: cover property (@(posedge sys_clk) disable iff (rst)
    meas_valid && !err_any ##1 meas_valid && !err_any);
endmodule

// ### verif/ptc_pkt_src.sv
/*
 Packet source model: presents one descriptor per send, then idles.
 Assumes the caller orders packets and keeps step and level as it wants.
*/
`timescale 1ns/100ps
module ptc_pkt_src (
  input wire logic sys_clk,
  output logic pkt_valid,
  output ptc_pkg::ptc_pkt_t pkt
);
  initial
  begin
    pkt_valid = 1'b0;
    pkt = '0;
  end
  task automatic send(input ptc_pkg::ptc_pkt_t p);
    @(posedge sys_clk);
    pkt_valid <= 1'b1;
    pkt <= p;
    @(posedge sys_clk);
    pkt_valid <= 1'b0;
    // Stale fields scrambled so they cannot pass by luck
    pkt <= ~p;
  endtask
endmodule

// ### verif/tb_top.sv
/*
 Self-checking bench for the timestamp checker.
 Assumes the package and the packet source model are compiled first.
*/
`timescale 1ns/100ps
module tb_top;
  typedef struct packed {
    logic [63:0] idx;
    logic [63:0] off;
    logic co;
    logic [5:0] err;
    logic [5:0] em;
    logic [63:0] step;
    logic [63:0] slp;
    logic [63:0] jit;
  } ptc_exp_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic pkt_valid;
  ptc_pkg::ptc_pkt_t pkt;
  logic [63:0] sample_freq = 64'h0000_0000_0000_2710;
  ptc_pkg::ptc_cat_t category = ptc_pkg::CAT_TIME_CONTINUOUS_SRC;
  logic time_of_day_reference = 1'b0;
  logic pkt_ready;
  ptc_pkg::ptc_meas_t meas;
  logic meas_valid;
  logic err_any;
  int failures = 0;
  int n_compared = 0;
  ptc_exp_t q[$];
  ptc_exp_t mx;
  logic [63:0] p_end, p_off, f_idx, f_step, f_lvl;
  logic [63:0] e_step, e_slp, e_jit;
  int n_dat, n_flw;
  logic [5:0] e_err, e_msk;
  logic [31:0] sec;
  logic [63:0] fr;
  always #12.5 sys_clk = ~sys_clk;
  ptc_pkt_src src (.sys_clk(sys_clk), .pkt_valid(pkt_valid), .pkt(pkt));
  ptc_checker uut (.sys_clk(sys_clk), .rst(rst), .pkt_valid(pkt_valid), .pkt(pkt),
    .sample_freq(sample_freq), .category(category),
    .time_of_day_reference(time_of_day_reference), .pkt_ready(pkt_ready), .meas(meas),
    .meas_valid(meas_valid), .err_any(err_any));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic restart(input ptc_pkg::ptc_cat_t c, input logic r_on, input logic [5:0] m);
    @(posedge sys_clk);
    rst <= 1'b1;
    category <= c;
    time_of_day_reference <= r_on;
    sample_freq <= 64'($urandom_range(100000, 1000));
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    n_dat = 0;
    n_flw = 0;
    e_err = '0;
    e_msk = m;
    e_step = '0;
    e_slp = '0;
    e_jit = '0;
    @(posedge sys_clk);
    check({63'h0, err_any}, 64'h0);
    check({63'h0, pkt_ready}, 64'h1);
  endtask
  task automatic settle(input logic any);
    repeat (3) @(posedge sys_clk);
    check(64'(q.size()), 64'h0);
    check({63'h0, err_any}, {63'h0, any});
  endtask
  task automatic push(input logic [63:0] idx, input logic [63:0] off, input logic co,
                      input ptc_pkg::ptc_pkt_t p);
    if (category inside {ptc_pkg::CAT_NON_TIME_RELEASE_SINK, ptc_pkg::CAT_TIME_CONTINUOUS_SINK,
                         ptc_pkg::CAT_SINK_BURST})
      e_err[3] = 1'b1;
    q.push_back('{idx, off, co, e_err, e_msk, e_step, e_slp, e_jit});
    src.send(p);
  endtask
  // Data packet whose capture time sits dt sample periods after its index
  task automatic dat(input logic fmt, input logic [31:0] s, input logic [63:0] f,
                     input logic [31:0] cnt, input logic [63:0] dt);
    logic [63:0] idx;
    idx = fmt ? (f + 64'h1) * sample_freq / 64'h0000_0000_3b9a_ca00 : f;
    idx = idx + 64'(s) * sample_freq;
    if (n_dat > 0 && idx != p_end)
      e_err[0] = 1'b1;
    if (n_dat > 0 && time_of_day_reference && dt != p_off)
      e_err[2] = 1'b1;
    // Flow offsets stay zero here, so follower data slope must be zero
    if (n_dat > 0 && n_flw > 1 && category == ptc_pkg::CAT_FOLLOWER && dt != p_off)
      e_err[5] = 1'b1;
    if (n_dat > 0)
    begin
      e_slp = dt - p_off;
      e_jit = (e_slp > e_jit) ? e_slp : e_jit;
    end
    p_end = idx + 64'(cnt);
    p_off = dt;
    n_dat++;
    push(idx, dt, 1'b1, '{n_dat[0] ? ptc_pkg::PKT_SAMPLE : ptc_pkg::PKT_CONTEXT, fmt, s, f, cnt,
      idx + dt, 32'h0});
  endtask
  task automatic flw(input logic [31:0] s, input logic [63:0] f, input logic [31:0] lvl);
    logic [63:0] idx;
    // Sample-count values sit on exact sample instants
    idx = 64'(s) * sample_freq + f;
    if (n_flw > 1 && idx - f_idx != f_step)
      e_err[1] = 1'b1;
    if (n_flw > 0 && category == ptc_pkg::CAT_FOLLOWER && 64'(lvl) != f_lvl)
      e_err[4] = 1'b1;
    if (n_flw > 0)
      e_step = idx - f_idx;
    f_step = idx - f_idx;
    f_idx = idx;
    f_lvl = 64'(lvl);
    n_flw++;
    push(idx, 64'h0, 1'b0, '{ptc_pkg::PKT_FLOW, 1'b0, s, f, 32'h0, idx, lvl});
  endtask
  always @(posedge sys_clk)
    if (meas_valid === 1'b1)
    begin
      if (q.size() == 0)
        check(64'h1, 64'h0);
      else
      begin
        mx = q.pop_front();
        check(meas.abs_idx, mx.idx);
        if (mx.co)
          check(meas.offset, mx.off);
        check({58'h0, meas.err & mx.em}, {58'h0, mx.err & mx.em});
        check(meas.step, mx.step);
        check(meas.slope, mx.slp);
        check(meas.jitter, mx.jit);
      end
    end
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(51194));
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    // Referenced source must keep offset flat; free-running one may drift
    for (int r = 0; r < 2; r++)
    begin
      restart(ptc_pkg::CAT_TIME_CONTINUOUS_SRC, r[0], 6'h3f);
      sec = 32'($urandom_range(999));
      fr = 64'($urandom_range(800));
      for (int i = 0; i < 4; i++)
        dat(1'b0, sec, fr + 64'(i * 32), 32'h20, 64'h10);
      dat(1'b0, sec, fr + 64'h80, 32'h20, 64'h13);
      dat(1'b0, sec, fr + 64'haa, 32'h20, 64'h13);
      settle(1'b1);
    end
    // Picosecond fractions; the first at second zero, products well inside 64 bits
    restart(ptc_pkg::CAT_TIME_CONTINUOUS_SRC, 1'b0, 6'h3f);
    for (int i = 0; i < 4; i++)
      dat(1'b1, (i == 0) ? 32'h0 : 32'($urandom_range(999)), 64'($urandom) * 64'hc8,
        32'h1, 64'h0);
    settle(e_err != 6'h0);
    // Constant flow step, then one changed step
    restart(ptc_pkg::CAT_MASTER, 1'b0, 6'h3f);
    for (int i = 0; i < 4; i++)
      flw(32'h7, 64'(i * 50), 32'h0);
    flw(32'h7, 64'hdc, 32'h0);
    settle(1'b1);
    // Follower buffer level steady, then moved; then data slope off the flow slope
    restart(ptc_pkg::CAT_FOLLOWER, 1'b0, 6'h30);
    for (int i = 0; i < 3; i++)
      flw(32'h9, 64'(i * 50), 32'h64);
    flw(32'h9, 64'h96, 32'h8c);
    dat(1'b0, 32'h9, 64'h0, 32'h20, 64'h10);
    dat(1'b0, 32'h9, 64'h20, 32'h20, 64'h14);
    settle(1'b1);
    // Every category: only sinks are faulted for emitting
    for (int c = 0; c < 8; c++)
    begin
      restart(ptc_pkg::ptc_cat_t'(c), 1'b0, 6'h08);
      dat(1'b0, 32'h5, 64'h0, 32'h8, 64'h0);
      repeat (3) @(posedge sys_clk);
      check(64'(q.size()), 64'h0);
    end
    tally_and_finish();
  end
endmodule
